// >>> src/spw_count.sv
// down counter for the enable arming window
// assumes load and stop come from logic on the same clock
`timescale 1ns/1ps
module spw_count #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic stop,
  input wire logic [W-1:0] value,
  output logic [W-1:0] count
);
  logic [W-1:0] count_r;

  // load wins over stop so a re-write restarts the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= value;
    end else if (stop) begin
      count_r <= '0;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign count = count_r;
endmodule // spw_count

// >>> src/spw_ctrl.sv
// self-programming controller: control register, arming window, page write,
// read blocking of the updatable section, completion interrupt level
// assumes core strobes, pointer, data pair and flash done are on clk
`timescale 1ns/1ps
module spw_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [spw_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic spm_strobe,
  input wire logic [spw_pkg::PTR_W-1:0] flash_ptr,
  input wire logic [15:0] data_pair,
  input wire logic eeprom_wr,
  input wire logic flash_done,
  input wire logic [spw_pkg::WORD_W-1:0] buf_rd_idx,
  output logic [15:0] buf_rd_data,
  output logic flash_start,
  output logic flash_op_write,
  output logic [spw_pkg::PAGE_W-1:0] flash_page,
  output logic core_halt,
  output logic updatable_read_block,
  output logic irq
);
  spw_pkg::spw_state_t state_r;
  logic [4:0] cmd_r;
  logic irq_en_r;
  logic busy_flag_r;
  logic core_halt_r;
  logic flash_start_r;
  logic flash_op_write_r;
  logic [spw_pkg::PAGE_W-1:0] flash_page_r;
  logic irq_r;
  logic read_block_r;
  logic [7:0] rdata_r;
  logic [2:0] arm_cnt;
  logic ctrl_wr;
  logic cmd_ok;
  logic arm_load;
  logic arm_live;
  logic spm_go;
  logic go_prog;
  logic go_rden;
  logic buf_wr;
  logic buf_clr;
  logic done_ev;
  logic [spw_pkg::PAGE_W-1:0] ptr_page;
  logic ptr_fixed;

  // decode of bus writes and accepted command patterns
  assign ctrl_wr = wr && (addr == spw_pkg::CTRL_OFFSET);
  assign cmd_ok = (wdata[4:0] == spw_pkg::CMD_LOAD) || (wdata[4:0] == spw_pkg::CMD_ERASE)
    || (wdata[4:0] == spw_pkg::CMD_WRITE) || (wdata[4:0] == spw_pkg::CMD_LOCK)
    || (wdata[4:0] == spw_pkg::CMD_RDEN);
  // commands are only taken while no operation runs
  assign arm_load = ctrl_wr && cmd_ok && (state_r != spw_pkg::SPW_BUSY);
  assign arm_live = (arm_cnt != 3'h0);
  assign spm_go = (state_r == spw_pkg::SPW_ARMED) && spm_strobe && arm_live;
  assign go_prog = spm_go && ((cmd_r == spw_pkg::CMD_ERASE) || (cmd_r == spw_pkg::CMD_WRITE));
  assign go_rden = spm_go && (cmd_r == spw_pkg::CMD_RDEN);
  assign done_ev = (state_r == spw_pkg::SPW_BUSY) && flash_done;
  // only a plain load takes the data pair; erase and write never do
  assign buf_wr = spm_go && (cmd_r == spw_pkg::CMD_LOAD);
  assign buf_clr = eeprom_wr
    || go_rden
    || (done_ev && flash_op_write_r);
  // page number sits above the word bits; other bits are the core's duty
  assign ptr_page = flash_ptr[spw_pkg::PAGE_LSB +: spw_pkg::PAGE_W];
  assign ptr_fixed = (ptr_page >= spw_pkg::FIXED_FIRST_PAGE);

  spw_count #(
    .W(3)
  ) u_arm (
    .clk(clk),
    .nrst(nrst),
    .load(arm_load),
    .stop(spm_go),
    .value(spw_pkg::ARM_CYCLES),
    .count(arm_cnt)
  );

  spw_pagebuf u_buf (
    .clk(clk),
    .nrst(nrst),
    .clr(buf_clr),
    .wr(buf_wr),
    .wr_idx(flash_ptr[spw_pkg::WORD_LSB +: spw_pkg::WORD_W]),
    .wr_data(data_pair),
    .rd_idx(buf_rd_idx),
    .rd_data(buf_rd_data)
  );

  // sequencer: command bits follow the state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= spw_pkg::SPW_IDLE;
      cmd_r <= spw_pkg::CMD_NONE;
    end else begin
      case (state_r)
        spw_pkg::SPW_IDLE: begin
          if (arm_load) begin
            state_r <= spw_pkg::SPW_ARMED;
            cmd_r <= wdata[4:0];
          end
        end
        spw_pkg::SPW_ARMED: begin
          if (go_prog) begin
            state_r <= spw_pkg::SPW_BUSY;
          end else if (spm_go) begin
            state_r <= spw_pkg::SPW_IDLE;
            cmd_r <= spw_pkg::CMD_NONE;
          end else if (arm_load) begin
            cmd_r <= wdata[4:0];
          end else if (!arm_live) begin
            // window lapsed with no store instruction
            state_r <= spw_pkg::SPW_IDLE;
            cmd_r <= spw_pkg::CMD_NONE;
          end
        end
        spw_pkg::SPW_BUSY: begin
          if (flash_done) begin
            state_r <= spw_pkg::SPW_IDLE;
            cmd_r <= spw_pkg::CMD_NONE;
          end
        end
        default: begin
          state_r <= spw_pkg::SPW_IDLE;
          cmd_r <= spw_pkg::CMD_NONE;
        end
      endcase
    end
  end

  // interrupt enable stays writable even while busy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_r <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_r <= wdata[spw_pkg::BIT_IRQ_EN];
    end
  end

  // busy flag: set by any operation on the updatable section, held past
  // completion until the read enable command runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_flag_r <= 1'b0;
    end else if (go_prog && !ptr_fixed) begin
      busy_flag_r <= 1'b1;
    end else if (go_rden) begin
      busy_flag_r <= 1'b0;
    end
  end

  // core halt only for the fixed section, released at done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_halt_r <= 1'b0;
    end else if (go_prog) begin
      core_halt_r <= ptr_fixed;
    end else if (done_ev) begin
      core_halt_r <= 1'b0;
    end
  end

  // updatable reads stay blocked through any running operation, fixed-section
  // ones too, and after completion for as long as the busy flag holds
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_block_r <= 1'b0;
    end else if (go_prog) begin
      read_block_r <= 1'b1;
    end else if (done_ev) begin
      read_block_r <= busy_flag_r;
    end else if (go_rden) begin
      read_block_r <= 1'b0;
    end
  end

  // flash command: start pulse with latched page and operation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flash_start_r <= 1'b0;
      flash_op_write_r <= 1'b0;
      flash_page_r <= '0;
    end else begin
      flash_start_r <= go_prog;
      if (go_prog) begin
        flash_op_write_r <= (cmd_r == spw_pkg::CMD_WRITE);
        flash_page_r <= ptr_page;
      end
    end
  end

  // completion interrupt is a plain level, no sticky state needed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_en_r && !cmd_r[spw_pkg::BIT_EN];
    end
  end

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= spw_pkg::CTRL_RESET;
    end else if (rd && (addr == spw_pkg::CTRL_OFFSET)) begin
      rdata_r <= {irq_en_r, busy_flag_r, 1'b0, cmd_r};
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign flash_start = flash_start_r;
  assign flash_op_write = flash_op_write_r;
  assign flash_page = flash_page_r;
  assign core_halt = core_halt_r;
  // read block covers the operation and the busy flag time after it
  assign updatable_read_block = read_block_r;
  assign irq = irq_r;

  // four live edges after the write, cleared on the fifth; a re-write on
  // that fifth edge restarts the window, so the quiet run covers it too
  sequence s_armed_quiet;
    arm_load ##1 (!spm_strobe && !ctrl_wr)[*5];
  endsequence

  // an accepted erase or write, first step of every operation
  sequence s_prog_start;
    go_prog;
  endsequence

  a_arm_window_lapse: assert property (@(posedge clk) disable iff (!nrst)
    s_armed_quiet |=> !cmd_r[spw_pkg::BIT_EN])
    else $error("enable bit not cleared after arming window");

  a_arm_window_open: assert property (@(posedge clk) disable iff (!nrst)
    arm_load ##1 (!ctrl_wr && !spm_strobe)[*3] |-> cmd_r[spw_pkg::BIT_EN] && arm_live)
    else $error("enable bit dropped inside arming window");

  a_enable_held_busy: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == spw_pkg::SPW_BUSY) |-> cmd_r[spw_pkg::BIT_EN])
    else $error("enable bit not held through operation");

  a_enable_clear_done: assert property (@(posedge clk) disable iff (!nrst)
    done_ev |=> !cmd_r[spw_pkg::BIT_EN])
    else $error("enable bit not cleared at completion");

  a_irq_level_follow: assert property (@(posedge clk) disable iff (!nrst)
    (irq_en_r && !cmd_r[spw_pkg::BIT_EN]) ##1 $stable(irq_en_r) |-> irq_r)
    else $error("interrupt level missing while enable bit clear");

  a_halt_fixed_write: assert property (@(posedge clk) disable iff (!nrst)
    (go_prog && ptr_fixed) |=> core_halt_r && flash_start_r)
    else $error("core not halted for fixed section write");

  a_fixed_stays_readable: assert property (@(posedge clk) disable iff (!nrst)
    (go_prog && !ptr_fixed) |=> !core_halt_r && updatable_read_block)
    else $error("core halted or updatable not blocked");

  a_block_during_op: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == spw_pkg::SPW_BUSY) |-> updatable_read_block)
    else $error("updatable read not blocked during operation");

  a_busy_clear_rden: assert property (@(posedge clk) disable iff (!nrst)
    go_rden |=> !busy_flag_r ##1 (rdata_r[spw_pkg::BIT_BUSY] == 1'b0 || !$past(rd)))
    else $error("busy flag not cleared by read enable command");

  a_no_load_in_write: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == spw_pkg::SPW_BUSY) || go_prog |-> !buf_wr)
    else $error("data pair stored during page write");

  a_buffer_clear_cause: assert property (@(posedge clk) disable iff (!nrst)
    (eeprom_wr || (done_ev && flash_op_write_r)) |-> buf_clr)
    else $error("page buffer not cleared");

  a_page_latched: assert property (@(posedge clk) disable iff (!nrst)
    s_prog_start |=> (flash_page_r == $past(ptr_page)))
    else $error("flash page not latched from pointer");

  a_block_fixed_op: assert property (@(posedge clk) disable iff (!nrst)
    s_prog_start ##0 ptr_fixed |=> updatable_read_block)
    else $error("updatable read not blocked during fixed operation");

  a_fixed_not_busy: assert property (@(posedge clk) disable iff (!nrst)
    (go_prog && ptr_fixed && !busy_flag_r) |=> !busy_flag_r)
    else $error("busy flag set by fixed section operation");

  a_busy_refuses_cmd: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == spw_pkg::SPW_BUSY && ctrl_wr && !flash_done)
    |=> (state_r == spw_pkg::SPW_BUSY) && (cmd_r == $past(cmd_r)))
    else $error("command taken while operation runs");

  a_halt_released_done: assert property (@(posedge clk) disable iff (!nrst)
    done_ev |=> !core_halt_r)
    else $error("core halt not released at completion");

  a_irq_off_armed: assert property (@(posedge clk) disable iff (!nrst)
    cmd_r[spw_pkg::BIT_EN] |=> !irq_r)
    else $error("interrupt level while enable bit set");

  a_rden_clears_buffer: assert property (@(posedge clk) disable iff (!nrst)
    go_rden |-> buf_clr)
    else $error("page buffer not cleared by read enable command");

  a_block_release: assert property (@(posedge clk) disable iff (!nrst)
    go_rden |=> !updatable_read_block)
    else $error("updatable read block not released");
endmodule // spw_ctrl

// >>> src/spw_pagebuf.sv
// temporary page buffer, one word per page position
// assumes the flash array reads it on the same clock
`timescale 1ns/1ps
module spw_pagebuf (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic wr,
  input wire logic [spw_pkg::WORD_W-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [spw_pkg::WORD_W-1:0] rd_idx,
  output logic [15:0] rd_data
);
  logic [15:0] mem_r [spw_pkg::PAGE_WORDS];
  logic [15:0] rd_data_r;

  // reset and clear give an erased page; a load in the clear cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < spw_pkg::PAGE_WORDS; i++) begin
        mem_r[i] <= spw_pkg::ERASED_WORD;
      end
    end else begin
      for (int i = 0; i < spw_pkg::PAGE_WORDS; i++) begin
        if (wr && (wr_idx == i[spw_pkg::WORD_W-1:0])) begin
          mem_r[i] <= wr_data;
        end else if (clr) begin
          mem_r[i] <= spw_pkg::ERASED_WORD;
        end
      end
    end
  end

  // registered read port for the flash array
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= spw_pkg::ERASED_WORD;
    end else begin
      rd_data_r <= mem_r[rd_idx];
    end
  end

  assign rd_data = rd_data_r;
endmodule // spw_pagebuf

// >>> src/spw_pkg.sv
// constants for the self-programming page write controller
// assumes one system clock shared by core, controller and flash array
package spw_pkg;
  // register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // control register bit positions
  localparam int BIT_EN = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_RDEN = 4;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  // accepted command patterns in the low five bits, and the idle pattern
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_RDEN = 5'h11;
  localparam logic [4:0] CMD_NONE = 5'h00;
  // arming window of the enable bit, in clock cycles
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  // flash pointer layout
  localparam int PTR_W = 16;
  localparam int WORD_LSB = 1;
  localparam int WORD_W = 6;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_W = 9;
  localparam int PAGE_WORDS = 64;
  localparam logic [8:0] FIXED_FIRST_PAGE = 9'h1c0;
  // erased buffer word
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  typedef enum logic [1:0] {
    SPW_IDLE,
    SPW_ARMED,
    SPW_BUSY
  } spw_state_t;
endpackage

// >>> verification/spw_flash_model.sv
// behavioural flash array: answers each start with a done pulse
// assumes start is a one-cycle pulse on the controller clock
`timescale 1ns/1ps
module spw_flash_model #(
  parameter int DELAY = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flash_start,
  output logic flash_done
);
  int cnt;
  // fixed busy time, long enough for the bench to poke the block mid-operation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt == 1);
      if (flash_start) cnt <= DELAY;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule // spw_flash_model

// >>> verification/testbench.sv
// self-checking bench for the page write controller
// assumes a flash model answering every start; the bench plays the core
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk, nrst, wr, rd, spm_strobe, eeprom_wr, flash_done, flash_start;
  logic flash_op_write, core_halt, updatable_read_block, irq, rd_seen;
  logic [7:0] addr, wdata, rdata, exp_rd;
  logic [15:0] flash_ptr, data_pair, buf_rd_data, rnd;
  logic [15:0] wd [4];
  logic [5:0] buf_rd_idx;
  logic [8:0] flash_page;
  logic [7:0] rd_q [$];
  int miscompares, check_count, starts, cycles;
  spw_ctrl i_spw_ctrl (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .spm_strobe(spm_strobe), .flash_ptr(flash_ptr), .data_pair(data_pair),
    .eeprom_wr(eeprom_wr), .flash_done(flash_done), .buf_rd_idx(buf_rd_idx),
    .buf_rd_data(buf_rd_data), .flash_start(flash_start), .flash_op_write(flash_op_write),
    .flash_page(flash_page), .core_halt(core_halt), .updatable_read_block(updatable_read_block),
    .irq(irq));
  spw_flash_model i_spw_flash_model (.clk(clk), .nrst(nrst), .flash_start(flash_start),
    .flash_done(flash_done));
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic final_report();
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data stands one cycle only, so it is checked in that cycle
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      exp_rd = rd_q.pop_front();
      `CHK("rdata", exp_rd, rdata)
    end
    rd_seen = rd;
    if (flash_start === 1'b1) starts++;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic store_program_memory_instruction(input logic [15:0] p, input logic [15:0] d);
    @(posedge clk);
    flash_ptr <= p;
    data_pair <= d;
    spm_strobe <= 1'b1;
    @(posedge clk);
    spm_strobe <= 1'b0;
  endtask
  task automatic peek(input logic [5:0] i, input logic [15:0] e);
    @(posedge clk);
    buf_rd_idx <= i;
    repeat (2) @(negedge clk);
    `CHK("buf_rd_data", e, buf_rd_data)
  endtask
  // bounded wait for the flash model to finish, then two cycles to settle
  task automatic wait_done();
    int n;
    n = 0;
    while (flash_done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK("flash_done", 1'b1, flash_done)
    repeat (2) @(negedge clk);
  endtask
  initial begin
    clk = 0; nrst = 0; addr = 0; wdata = 0; wr = 0; rd = 0; spm_strobe = 0;
    flash_ptr = 0; data_pair = 0; eeprom_wr = 0; buf_rd_idx = 0; rnd = 16'h0010;
    rd_seen = 0; miscompares = 0; check_count = 0; starts = 0; cycles = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h05, 8'h00);
    // fill four buffer words with random data, then lose them to an eeprom write
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wd[i] = rnd;
      wr_reg(8'h00, 8'h01);
      store_program_memory_instruction({9'h005, 6'(i), 1'b0}, rnd);
    end
    for (int i = 0; i < 4; i++) peek(6'(i), wd[i]);
    @(posedge clk) eeprom_wr <= 1'b1;
    @(posedge clk) eeprom_wr <= 1'b0;
    for (int i = 0; i < 4; i++) peek(6'(i), 16'hffff);
    wr_reg(8'h00, 8'h01);
    store_program_memory_instruction({9'h005, 6'h02, 1'b0}, wd[2]);
    // store lands on the fifth edge after the write, one past the window
    wr_reg(8'h00, 8'h85);
    repeat (3) @(posedge clk);
    store_program_memory_instruction({9'h005, 7'h00}, 16'h0000);
    rd_reg(8'h00, 8'h80);
    `CHK("irq", 1'b1, irq)
    `CHK("starts", 0, starts)
    // page write to the updatable section on the last live edge, data pair garbage
    wr_reg(8'h00, 8'h85);
    repeat (2) @(posedge clk);
    store_program_memory_instruction({9'h005, 7'h00}, lfsr(rnd));
    rd_reg(8'h00, 8'hc5);
    `CHK("core_halt", 1'b0, core_halt)
    `CHK("read_block", 1'b1, updatable_read_block)
    `CHK("flash_page", 9'h005, flash_page)
    `CHK("op_write", 1'b1, flash_op_write)
    `CHK("irq", 1'b0, irq)
    peek(6'h00, 16'hffff);
    // a command written mid-operation is refused
    wr_reg(8'h00, 8'h85);
    rd_reg(8'h00, 8'hc5);
    wait_done();
    `CHK("irq", 1'b1, irq)
    `CHK("starts", 1, starts)
    peek(6'h02, 16'hffff);
    rd_reg(8'h00, 8'hc0);
    wr_reg(8'h00, 8'h91);
    store_program_memory_instruction(16'h0000, 16'h0000);
    rd_reg(8'h00, 8'h80);
    `CHK("read_block", 1'b0, updatable_read_block)
    // page write to the fixed section stalls the core
    wr_reg(8'h00, 8'h05);
    store_program_memory_instruction({9'h1c0, 7'h00}, 16'h0000);
    @(negedge clk);
    `CHK("core_halt", 1'b1, core_halt)
    `CHK("read_block", 1'b1, updatable_read_block)
    `CHK("flash_page", 9'h1c0, flash_page)
    wait_done();
    `CHK("core_halt", 1'b0, core_halt)
    `CHK("read_block", 1'b0, updatable_read_block)
    `CHK("irq", 1'b0, irq)
    // erase blocks updatable reads too
    wr_reg(8'h00, 8'h03);
    store_program_memory_instruction({9'h006, 7'h00}, 16'h0000);
    @(negedge clk);
    `CHK("read_block", 1'b1, updatable_read_block)
    `CHK("op_write", 1'b0, flash_op_write)
    wait_done();
    wr_reg(8'h00, 8'h11);
    store_program_memory_instruction(16'h0000, 16'h0000);
    wr_reg(8'h00, 8'h07);
    rd_reg(8'h00, 8'h00);
    // a word loaded before a mid-run reset must not survive it
    wr_reg(8'h00, 8'h01);
    store_program_memory_instruction({9'h005, 6'h03, 1'b0}, wd[3]);
    peek(6'h03, wd[3]);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    peek(6'h03, 16'hffff);
    rd_reg(8'h00, 8'h00);
    // let the last read reach the watcher before the verdict
    repeat (2) @(negedge clk);
    `CHK("starts", 3, starts)
    `CHK("rd_q", 0, rd_q.size())
    final_report();
  end
endmodule // testbench
